// ==== adpc_pkg.sv ====
package adpc_pkg;
	localparam int ADPC_WIDTH         = 11;
	localparam int ADPC_LATENCY       = 6;
	localparam int ADPC_CLK_MHZ       = 100;
	localparam int ADPC_RECOVERY_NS   = 300;
	localparam int ADPC_RECOVERY_CYC  = (ADPC_RECOVERY_NS * ADPC_CLK_MHZ + 999) / 1000;
	localparam int ADPC_CONV_MIN_MHZ  = 10;
	localparam int ADPC_CONV_MAX_MHZ  = 80;
	localparam int ADPC_CONV_DIV      = 4;
	localparam int ADPC_DIV_MAX       = 256;
	localparam logic [ADPC_WIDTH-1:0] ADPC_WORD_ZERO = 11'h000;
	localparam logic [ADPC_WIDTH-1:0] ADPC_WORD_UNDEF = 11'h7FF;
endpackage

// ==== adpc_if.sv ====
`timescale 1ns/1ps
interface adpc_if;
	import adpc_pkg::*;
	logic                  conv_clk_en;
	logic                  output_enable_n;
	logic                  sleep_request;
	logic [ADPC_WIDTH-1:0] sample_word;
	logic [ADPC_WIDTH-1:0] sample_word_oe;
	modport converter (
		input  conv_clk_en,
		input  output_enable_n,
		input  sleep_request,
		output sample_word,
		output sample_word_oe
	);
	modport capture (
		output conv_clk_en,
		output output_enable_n,
		output sleep_request,
		input  sample_word,
		input  sample_word_oe
	);
endinterface

// ==== adpc_converter.sv ====
`timescale 1ns/1ps
// Functional notes
// - clock stays within 10 to 80 MHz
// - clock never below 1 MSPS
// - clock duty cycle near 50 percent; here conv_clk_en is a one-cycle pulse every four clock_in cycles (25 percent)
// - output enable high floats data pins
// - conversion continues regardless of output enable
// - sleep request holds low power state
// - data pins undefined while asleep
// - sleep corrupts all in-flight samples
// - wait recovery time after sleep release
// - eleven bit offset binary result word
// - capture on rising conversion clock edge
module adpc_converter
	import adpc_pkg::*;
#(
	parameter int WIDTH   = ADPC_WIDTH,
	parameter int LATENCY = ADPC_LATENCY
) (
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] analog_code_in,
	output logic                  powered_down_out,
	adpc_if.converter             link
);

	////////////////////////////////////////////////////////////
	// the core steps only on conversion pulses from the capture side
	// power state of the converter core, one-hot
	typedef enum logic [1:0] {
		ADPC_PWR_AWAKE  = 2'b01,
		ADPC_PWR_ASLEEP = 2'b10
	} adpc_pwr_t;

	////////////////////////////////////////////////////////////
	// words and pin masks at the parameter width
	localparam logic [WIDTH-1:0] WORD_ZERO  = WIDTH'(ADPC_WORD_ZERO);
	localparam logic [WIDTH-1:0] WORD_UNDEF = WIDTH'(ADPC_WORD_UNDEF);
	localparam logic [WIDTH-1:0] PINS_ON    = {WIDTH{1'b1}};
	localparam logic [WIDTH-1:0] PINS_OFF   = {WIDTH{1'b0}};

	////////////////////////////////////////////////////////////
	// pipeline stages and their next values
	logic [WIDTH-1:0] pipe      [LATENCY];
	logic [WIDTH-1:0] next_pipe [LATENCY];
	logic [WIDTH-1:0] stage_in  [LATENCY];

	// output word and pin enables
	logic [WIDTH-1:0] out_word;
	logic [WIDTH-1:0] next_out_word;
	logic [WIDTH-1:0] pins_enable;

	// power state
	adpc_pwr_t        pwr_state;
	adpc_pwr_t        next_pwr_state;

	// decoded controls
	logic             step;
	logic             wipe;
	logic             drive_pins;

	////////////////////////////////////////////////////////////
	// next value of one held word: a sleep wipes it,
	// a conversion step loads it, otherwise it holds;
	// shared by every pipeline stage and the output register
	function automatic logic [WIDTH-1:0] stage_next(
		input logic             wipe_now,
		input logic             advance,
		input logic [WIDTH-1:0] incoming,
		input logic [WIDTH-1:0] current
	);
		logic [WIDTH-1:0] result;
		if (wipe_now) begin
			result = WORD_UNDEF;
		end else if (advance) begin
			result = incoming;
		end else begin
			result = current;
		end
		return result;
	endfunction

	// enable mask of the data pins
	function automatic logic [WIDTH-1:0] pins_for(
		input logic drive_now
	);
		logic [WIDTH-1:0] mask;
		if (drive_now) begin
			mask = PINS_ON;
		end else begin
			mask = PINS_OFF;
		end
		return mask;
	endfunction

	////////////////////////////////////////////////////////////
	// control decode
	// a sleep request also covers the capture side's reset
	assign wipe       = link.sleep_request;
	// no stepping while asleep: the wipe has priority
	assign step       = link.conv_clk_en && !link.sleep_request;
	assign drive_pins = !link.output_enable_n;

	////////////////////////////////////////////////////////////
	// power state follows sleep
	// any code other than the two legal ones falls back to awake
	always_comb begin
		next_pwr_state = pwr_state;
		unique case (pwr_state)
			ADPC_PWR_AWAKE: begin
				if (link.sleep_request) begin
					next_pwr_state = ADPC_PWR_ASLEEP;
				end
			end

			ADPC_PWR_ASLEEP: begin
				if (!link.sleep_request) begin
					next_pwr_state = ADPC_PWR_AWAKE;
				end
			end

			default: begin
				next_pwr_state = ADPC_PWR_AWAKE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pwr_state <= ADPC_PWR_AWAKE;
		end else begin
			pwr_state <= next_pwr_state;
		end
	end

	// registered state: the status lags the request by one cycle
	assign powered_down_out = (pwr_state == ADPC_PWR_ASLEEP);

	////////////////////////////////////////////////////////////
	// input of each stage: the pin code first, then the stage before
	for (genvar g = 0; g < LATENCY; g++) begin : g_source
		if (g == 0) begin : g_first
			assign stage_in[g] = analog_code_in;
		end else begin : g_rest
			assign stage_in[g] = pipe[g-1];
		end
	end

	for (genvar g = 0; g < LATENCY; g++) begin : g_next
		assign next_pipe[g] = stage_next(
			wipe,
			step,
			stage_in[g],
			pipe[g]
		);
	end

	////////////////////////////////////////////////////////////
	// stage registers
	// fixed pipeline stepping
	// stages move only on conversion pulses, whatever the output enable
	for (genvar g = 0; g < LATENCY; g++) begin : g_stage
		always_ff @(posedge clock_in) begin
			if (rst_in) begin
				pipe[g] <= WORD_ZERO;
			end else begin
				pipe[g] <= next_pipe[g];
			end
		end
	end

	////////////////////////////////////////////////////////////
	// word undefined while asleep
	// the wipe pattern is fixed; the capture side must not trust it
	assign next_out_word = stage_next(
		wipe,
		step,
		pipe[LATENCY-1],
		out_word
	);

	////////////////////////////////////////////////////////////
	// output register
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			out_word <= WORD_ZERO;
		end else begin
			out_word <= next_out_word;
		end
	end

	////////////////////////////////////////////////////////////
	// word on the data pins
	// offset binary straight from the output register, no recoding
	// a fresh word appears only on a conversion pulse
	assign link.sample_word = out_word;

	// drive only while enabled
	// the mask is not registered, so the pins float at once
	assign pins_enable         = pins_for(drive_pins);
	assign link.sample_word_oe = pins_enable;

endmodule

// ==== adpc_capture.sv ====
`timescale 1ns/1ps
module adpc_capture
	import adpc_pkg::*;
#(
	parameter int WIDTH        = ADPC_WIDTH,
	parameter int LATENCY      = ADPC_LATENCY,
	parameter int DIV          = ADPC_CONV_DIV,
	parameter int RECOVERY_CYC = ADPC_RECOVERY_CYC
) (
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	input  wire logic             read_enable_in,
	input  wire logic             sleep_in,
	output logic [WIDTH-1:0]      sample_out,
	output logic                  sample_valid_out,
	adpc_if.capture               link
);
	////////////////////////////////////////////////////////////
	logic [7:0]  div_cnt;
	logic [15:0] settle_cnt;
	logic [7:0]  fill_cnt;
	logic        conv_en;
	wire div_last = (div_cnt == 8'(DIV - 1));
	wire settled  = (settle_cnt == 16'h0000);
	wire filled   = (fill_cnt == 8'(LATENCY + 1));
	wire word_ok  = settled && filled && !sleep_in && read_enable_in;
	////////////////////////////////////////////////////////////
	always_ff @(posedge clock_in) begin
		if (rst_in || div_last) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end
	assign conv_en = div_last && !rst_in;
	////////////////////////////////////////////////////////////
	// recovery wait after sleep
	always_ff @(posedge clock_in) begin
		if (rst_in || sleep_in) begin
			settle_cnt <= 16'(RECOVERY_CYC);
			fill_cnt   <= 8'h00;
		end else begin
			if (!settled) begin
				settle_cnt <= settle_cnt - 16'h0001;
			end
			if (conv_en && !filled) begin
				fill_cnt <= fill_cnt + 8'h01;
			end
		end
	end
	////////////////////////////////////////////////////////////
	// capture on conversion edge
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sample_out       <= WIDTH'(ADPC_WORD_ZERO);
			sample_valid_out <= 1'b0;
		end else begin
			sample_valid_out <= conv_en && word_ok;
			if (conv_en && word_ok) begin
				sample_out <= link.sample_word;
			end
		end
	end
	assign link.conv_clk_en     = conv_en;
	assign link.output_enable_n = !read_enable_in;
	assign link.sleep_request   = sleep_in || rst_in;
endmodule

// ==== adpc_link_sva.sv ====
`timescale 1ns/1ps
module adpc_link_sva
	import adpc_pkg::*;
(
	input wire logic                  clock_in,
	input wire logic                  rst_in,
	input wire logic                  conv_clk_en,
	input wire logic                  output_enable_n,
	input wire logic                  sleep_request,
	input wire logic [ADPC_WIDTH-1:0] sample_word,
	input wire logic [ADPC_WIDTH-1:0] sample_word_oe
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	sequence undef_s;
		sample_word == ADPC_WORD_UNDEF;
	endsequence
	oe_float_a: assert property (output_enable_n |-> sample_word_oe == 11'h000)
		else $error("pins driven while disabled");
	oe_drive_a: assert property (!output_enable_n |-> sample_word_oe == 11'h7FF)
		else $error("pins floating while enabled");
	sleep_fill_a: assert property (sleep_request |=> undef_s)
		else $error("word defined while asleep");
	stale_lost_a: assert property ($fell(sleep_request) && !$past(rst_in) |-> undef_s [*8])
		else $error("old sample after wake");
	word_hold_a: assert property (!conv_clk_en && !sleep_request |=> $stable(sample_word))
		else $error("word moved between pulses");
	conv_space_a: assert property (conv_clk_en |=> !conv_clk_en [*3])
		else $error("conversion pulses too close");
endmodule

// ==== adc_digital_port_control_tb.sv ====
`timescale 1ns/1ps
module adc_digital_port_control_tb
	import adpc_pkg::*;
;
	logic                  clock_in = 0;
	logic                  rst_in = 1;
	logic                  read_enable_in = 1;
	logic                  sleep_in = 0;
	logic [ADPC_WIDTH-1:0] code = 11'h155;
	logic [ADPC_WIDTH-1:0] sample_out;
	logic                  sample_valid_out;
	logic                  powered_down_out;
	int                    err_count = 0;
	int                    num_checks = 0;
	int                    n;
	int                    p;
	adpc_if link ();
	always #5 clock_in = ~clock_in;
	adpc_converter i_adpc_converter (.clock_in(clock_in), .rst_in(rst_in), .analog_code_in(code),
		.powered_down_out(powered_down_out), .link(link));
	adpc_capture i_adpc_capture (.clock_in(clock_in), .rst_in(rst_in), .read_enable_in(read_enable_in),
		.sleep_in(sleep_in), .sample_out(sample_out), .sample_valid_out(sample_valid_out), .link(link));
	adpc_link_sva i_adpc_link_sva (.clock_in(clock_in), .rst_in(rst_in), .conv_clk_en(link.conv_clk_en),
		.output_enable_n(link.output_enable_n), .sleep_request(link.sleep_request),
		.sample_word(link.sample_word), .sample_word_oe(link.sample_word_oe));
	task check(input logic [ADPC_WIDTH-1:0] seen, input logic [ADPC_WIDTH-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task wait_valid;
		n = 0;
		do begin
			@(negedge clock_in);
			n++;
		end while (sample_valid_out !== 1'b1 && n < 300);
		if (n == 300) begin
			err_count++;
			conclude;
		end
	endtask
	task drive(input logic [ADPC_WIDTH-1:0] c, input logic re, input logic sl, input int k);
		@(posedge clock_in);
		code <= c;
		read_enable_in <= re;
		sleep_in <= sl;
		repeat (k) @(posedge clock_in);
		@(negedge clock_in);
	endtask
	initial begin
		repeat (20) @(posedge clock_in);
		rst_in <= 1'b0;
		wait_valid;
		check(sample_out, 11'h155);
		$display("startup test done");
		drive(11'h2AA, 1, 0, 0);
		p = 0;
		repeat (100) begin
			if (link.sample_word !== 11'h2AA) p += link.conv_clk_en;
			@(negedge clock_in);
		end
		check(p[10:0], 11'(ADPC_LATENCY + 1));
		$display("latency test done");
		drive(11'h0F0, 0, 0, 40);
		check(link.sample_word_oe, 11'h000);
		check(link.sample_word, 11'h0F0);
		drive(11'h0F0, 1, 0, 2);
		check(link.sample_word_oe, 11'h7FF);
		$display("enable test done");
		drive(11'h0F0, 1, 1, 3);
		check(11'(powered_down_out), 11'h001);
		check(link.sample_word, 11'h7FF);
		drive(11'h321, 1, 0, 0);
		wait_valid;
		check(11'(n > ADPC_RECOVERY_CYC), 11'h001);
		check(sample_out, 11'h321);
		$display("sleep test done");
		conclude;
	end
endmodule
